// ===== logic/fcl_loader.v
// Power-up switch sampling, parameter restore and status logic of the fieldbus coupler.
//
// How it works
// - Baud codes 0..8 map to rates; rest invalid.
// - Default baud code is 0001, 20 kbit/s.
// - Node number 1..127 valid, zero invalid.
// - Default node number is 32.
// - Switch position 1 is the LSB.
// - MSB set selects service; 0x81 restores defaults.
// - Service mode keeps the node off bus.
// - Switches sampled once after power-up only.
// - Service result on receive LED, faults on alarm.
// - Receive LED lights five seconds after power-up.
// - Store write failure lights alarm LED and relay.
// - Parameters kept in EEPROM, reloaded at start.
// - Module configuration change rewrites defaults.
// - Reset Node from master restores defaults.
// - Pre-operational and emergency after start-up delay.
`default_nettype none
`include "fcl_map.vh"

module fcl_loader #(
  parameter [31:0] LED_CYC   = `FCL_LED_DELAY_S * `FCL_CLK_HZ,
  parameter [31:0] PREOP_CYC = `FCL_PREOP_DELAY_S * `FCL_CLK_HZ
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire [3:0]  baud_sw_i,
  input  wire [7:0]  node_sw_i,
  input  wire        cfg_change_i,
  input  wire        reset_node_i,
  output reg         ee_req_o,
  output reg         ee_we_o,
  output reg  [3:0]  ee_addr_o,
  output reg  [15:0] ee_wdata_o,
  input  wire [15:0] ee_rdata_i,
  input  wire        ee_done_i,
  input  wire        ee_err_i,
  output reg         bus_en_o,
  output reg  [3:0]  baud_code_o,
  output reg  [9:0]  baud_kbps_o,
  output reg  [6:0]  node_id_o,
  output reg         preop_o,
  output reg         emcy_o,
  output reg         rx_led_o,
  output reg         alarm_led_o,
  output reg         alarm_relay_o,
  output reg         irq_o
);

  // ==========================================================================
  // States
  localparam [6:0] ST_SAMPLE  = 7'h01;
  localparam [6:0] ST_LOAD    = 7'h02;
  localparam [6:0] ST_RESTORE = 7'h04;
  localparam [6:0] ST_SAVE    = 7'h08;
  localparam [6:0] ST_RUN     = 7'h10;
  localparam [6:0] ST_SERVICE = 7'h20;
  localparam [6:0] ST_OFFLINE = 7'h40;

  // ==========================================================================
  // Decode helpers
  // Rate in kbit/s for a baud code, zero for an invalid code.
  function [9:0] fcl_rate;
    input [3:0] code;
    begin
      case (code)
        4'h0:    fcl_rate = 10'd10;
        4'h1:    fcl_rate = 10'd20;
        4'h2:    fcl_rate = 10'd50;
        4'h3:    fcl_rate = 10'd100;
        4'h4:    fcl_rate = 10'd125;
        4'h5:    fcl_rate = 10'd250;
        4'h6:    fcl_rate = 10'd500;
        4'h7:    fcl_rate = 10'd800;
        4'h8:    fcl_rate = 10'd1000;
        default: fcl_rate = 10'd0;
      endcase
    end
  endfunction

  // A node number is valid from 1 to 127.
  function fcl_node_ok;
    input [7:0] sw;
    begin
      fcl_node_ok = (sw != 8'h00) && (sw <= `FCL_NODE_MAX);
    end
  endfunction

  // ==========================================================================
  // Switch synchronisers
  // Bit 0 of each vector is switch position 1, so no reordering is needed.
  wire [11:0] sw_raw = {node_sw_i, baud_sw_i};
  reg  [11:0] sw_s1;
  reg  [11:0] sw_s2;
  reg  [11:0] sw_s3;
  reg  [11:0] sw_filt;

  always @(posedge clk_i) begin
    sw_s1 <= sw_raw;
    sw_s2 <= sw_s1;
    sw_s3 <= sw_s2;
  end

  // A bit is believed only once the last two stages agree.
  genvar gi;
  generate
    for (gi = 0; gi < 12; gi = gi + 1) begin : g_filt
      always @(posedge clk_i) begin
        if (rst_i) begin
          sw_filt[gi] <= 1'b0;
        end else if (sw_s2[gi] == sw_s3[gi]) begin
          sw_filt[gi] <= sw_s3[gi];
        end
      end
    end
  endgenerate

  // ==========================================================================
  // State and engine registers
  reg [6:0]  state;
  reg [7:0]  settle;
  reg [3:0]  baud_cap;
  reg [7:0]  node_cap;
  reg        svc;
  reg        restore_ok;
  reg        err;
  reg        pend_restore;
  reg [3:0]  idx;
  reg [31:0] tmr;
  reg [4:0]  irq_stat;
  reg [4:0]  irq_mask;
  reg [4:0]  ev;
  reg        wb_st1;

  // ==========================================================================
  // Bus decode
  wire       wb_req    = wb_cyc_i & wb_stb_i;
  wire       hit_param = (wb_adr_i[7:6] == 2'b01);
  // Gated by the request so that stale idle bus lines never hold off a restore.
  wire       param_wr  = wb_req & hit_param & wb_we_i;
  // Parameter writes go to the store, so they wait for an idle engine.
  wire       wb_ready  = ~param_wr | (state == ST_RUN);
  wire       wb_go     = wb_st1 & wb_ready;
  wire       wr_go     = wb_go & wb_we_i;
  wire [7:0] reg_adr   = {wb_adr_i[7:2], 2'b00};
  wire       eng_busy  = (state == ST_LOAD) | (state == ST_RESTORE);
  wire       ee_ack    = ee_req_o & ee_done_i;
  wire       last_word = (idx == 4'hf);

  // ==========================================================================
  // Parameter store
  // During load and restore the engine owns the store; parameter writes from the bus are held off.
  wire        mem_we    = eng_busy ? ee_ack : (wr_go & hit_param & (&wb_sel_i[1:0]));
  wire [3:0]  mem_addr  = eng_busy ? idx : wb_adr_i[5:2];
  wire [15:0] mem_wdata = (state == ST_LOAD) ? ee_rdata_i :
                          (state == ST_RESTORE) ? `FCL_PARAM_DEFAULT : wb_dat_i[15:0];
  wire [15:0] mem_rdata;

  fcl_param_mem u_mem (
    .clk_i   (clk_i),
    .we_i    (mem_we),
    .addr_i  (mem_addr),
    .wdata_i (mem_wdata),
    .rdata_o (mem_rdata)
  );

  // ==========================================================================
  // Restore triggers
  // A trigger during a busy phase is kept and served once the node runs.
  wire trig = cfg_change_i | reset_node_i |
              (wr_go & (reg_adr == `FCL_OFS_CTRL) & wb_sel_i[0] &
               wb_dat_i[`FCL_CTRL_RESTORE]);

  always @(posedge clk_i) begin
    if (rst_i) begin
      pend_restore <= 1'b0;
    end else if (trig) begin
      pend_restore <= 1'b1;
    end else if (state == ST_RUN && !param_wr) begin
      pend_restore <= 1'b0;
    end
  end

  // ==========================================================================
  // Time since power-up, saturating at the longer of the two delays.
  always @(posedge clk_i) begin
    if (rst_i) begin
      tmr <= 32'h0000_0000;
    end else if (tmr < LED_CYC || tmr < PREOP_CYC) begin
      tmr <= tmr + 32'h0000_0001;
    end
  end

  // ==========================================================================
  // Main sequencer
  always @(posedge clk_i) begin
    if (rst_i) begin
      state      <= ST_SAMPLE;
      settle     <= 8'h00;
      baud_cap   <= `FCL_BAUD_DEFAULT;
      node_cap   <= `FCL_NODE_DEFAULT;
      svc        <= 1'b0;
      restore_ok <= 1'b0;
      err        <= 1'b0;
      idx        <= 4'h0;
      ee_req_o   <= 1'b0;
      ee_we_o    <= 1'b0;
      ev         <= 5'h00;
    end else begin
      ev    <= 5'h00;
      ev[`FCL_EV_CFG_CHG]  <= cfg_change_i;
      ev[`FCL_EV_RST_NODE] <= reset_node_i;
      // One word per store handshake; request drops for a cycle between words.
      if (ee_ack) begin
        ee_req_o <= 1'b0;
        if (ee_err_i) begin
          err <= 1'b1;
          ev[`FCL_EV_EE_ERR] <= 1'b1;
        end
      end
      case (state)
        ST_SAMPLE: begin
          // Capture once after the synchronisers settle; never again.
          if (settle == `FCL_SETTLE_CYC) begin
            baud_cap <= sw_filt[3:0];
            node_cap <= sw_filt[11:4];
            idx      <= 4'h0;
            if (sw_filt[11]) begin
              svc <= 1'b1;
              if (sw_filt[11:4] == `FCL_SVC_RESTORE) begin
                state <= ST_RESTORE;
              end else begin
                state <= ST_SERVICE;
              end
            end else if (fcl_node_ok(sw_filt[11:4]) && sw_filt[3:0] <= `FCL_BAUD_MAX) begin
              state <= ST_LOAD;
            end else begin
              state <= ST_OFFLINE;
            end
          end else begin
            settle <= settle + 8'h01;
          end
        end
        ST_LOAD, ST_RESTORE: begin
          ee_we_o <= (state == ST_RESTORE);
          if (!ee_req_o && !ee_ack) begin
            ee_req_o <= 1'b1;
          end
          if (ee_ack) begin
            idx <= idx + 4'h1;
            if (last_word) begin
              if (state == ST_RESTORE) begin
                restore_ok <= ~(err | ee_err_i);
                ev[`FCL_EV_RESTORED] <= 1'b1;
              end
              state <= svc ? ST_SERVICE : ST_RUN;
            end
          end
        end
        ST_SAVE: begin
          if (ee_ack) begin
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          idx <= 4'h0;
          if (wr_go && hit_param && (&wb_sel_i[1:0])) begin
            ee_we_o  <= 1'b1;
            ee_req_o <= 1'b1;
            state    <= ST_SAVE;
          end else if (pend_restore && !param_wr) begin
            state <= ST_RESTORE;
          end
        end
        ST_SERVICE, ST_OFFLINE: begin
          state <= state;
        end
        default: begin
          state <= ST_SAMPLE;
        end
      endcase
    end
  end

  // The store port mirrors the engine word or the word just written by software.
  always @(posedge clk_i) begin
    if (rst_i) begin
      ee_addr_o  <= 4'h0;
      ee_wdata_o <= 16'h0000;
    end else if (eng_busy) begin
      ee_addr_o  <= idx;
      ee_wdata_o <= `FCL_PARAM_DEFAULT;
    end else if (state == ST_RUN) begin
      ee_addr_o  <= wb_adr_i[5:2];
      ee_wdata_o <= wb_dat_i[15:0];
    end
  end

  // ==========================================================================
  // Network-facing outputs and indicators
  always @(posedge clk_i) begin
    if (rst_i) begin
      bus_en_o      <= 1'b0;
      baud_code_o   <= `FCL_BAUD_DEFAULT;
      baud_kbps_o   <= 10'd0;
      node_id_o     <= 7'h00;
      preop_o       <= 1'b0;
      emcy_o        <= 1'b0;
      rx_led_o      <= 1'b0;
      alarm_led_o   <= 1'b0;
      alarm_relay_o <= 1'b0;
    end else begin
      bus_en_o    <= ~svc & ((state == ST_RUN) | (state == ST_SAVE) |
                             (state == ST_RESTORE));
      baud_code_o <= baud_cap;
      baud_kbps_o <= fcl_rate(baud_cap);
      node_id_o   <= node_cap[6:0];
      emcy_o      <= 1'b0;
      // Enter pre-operational once, with one emergency pulse in the same cycle.
      if (bus_en_o && !preop_o && tmr >= PREOP_CYC) begin
        preop_o <= 1'b1;
        emcy_o  <= 1'b1;
      end
      rx_led_o      <= svc & restore_ok & (tmr >= LED_CYC);
      alarm_led_o   <= err;
      alarm_relay_o <= err;
    end
  end

  // ==========================================================================
  // Interrupt status, mask and output
  // A new event wins over a write-one-to-clear in the same cycle.
  wire [4:0] stat_clr = (wr_go && reg_adr == `FCL_OFS_IRQ_STAT && wb_sel_i[0]) ?
                        wb_dat_i[4:0] : 5'h00;
  wire [4:0] ev_all   = ev | {4'h0, 1'b0} |
                        {2'b00, bus_en_o & ~preop_o & (tmr >= PREOP_CYC), 2'b00};

  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat <= 5'h00;
      irq_mask <= `FCL_MASK_RESET;
      irq_o    <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~stat_clr) | ev_all;
      if (wr_go && reg_adr == `FCL_OFS_IRQ_MASK && wb_sel_i[0]) begin
        irq_mask <= wb_dat_i[4:0];
      end
      irq_o <= |(irq_stat & irq_mask);
    end
  end

  // ==========================================================================
  // Wishbone slave
  // Ack comes two edges after the request so that store reads are registered.
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_st1   <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_st1   <= wb_req & ~wb_ack_o & ~wb_go;
      wb_ack_o <= wb_go;
      if (wb_go && !wb_we_i) begin
        if (hit_param) begin
          wb_dat_o <= {16'h0000, mem_rdata};
        end else begin
          case (reg_adr)
            `FCL_OFS_STATUS:   wb_dat_o <= {13'h0, rx_led_o, err, preop_o, bus_en_o, svc,
                                            fcl_node_ok(node_cap),
                                            (baud_cap <= `FCL_BAUD_MAX),
                                            node_cap, baud_cap};
            `FCL_OFS_IRQ_STAT: wb_dat_o <= {27'h0, irq_stat};
            `FCL_OFS_IRQ_MASK: wb_dat_o <= {27'h0, irq_mask};
            default:           wb_dat_o <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

endmodule

`default_nettype wire

// ===== logic/fcl_map.vh
// Offsets, field positions, reset values and timing figures of the switch configuration loader.
`ifndef FCL_MAP_VH
`define FCL_MAP_VH

// ==========================================================================
// Register offsets (byte addresses on the Wishbone bus)
`define FCL_OFS_CTRL       8'h00
`define FCL_OFS_STATUS     8'h04
`define FCL_OFS_IRQ_STAT   8'h08
`define FCL_OFS_IRQ_MASK   8'h0c
`define FCL_OFS_PARAM      8'h40

// ==========================================================================
// Field positions
`define FCL_CTRL_RESTORE   0
`define FCL_EV_RESTORED    0
`define FCL_EV_EE_ERR      1
`define FCL_EV_PREOP       2
`define FCL_EV_CFG_CHG     3
`define FCL_EV_RST_NODE    4
`define FCL_EV_W           5

// ==========================================================================
// Switch codes
`define FCL_BAUD_MAX       4'h8
`define FCL_BAUD_DEFAULT   4'h1
`define FCL_NODE_DEFAULT   8'h20
`define FCL_SVC_RESTORE    8'h81
`define FCL_NODE_MAX       8'h7f

// ==========================================================================
// Reset values and parameter store
`define FCL_MASK_RESET     5'h00
`define FCL_PARAM_DEFAULT  16'h0000
`define FCL_PARAM_WORDS    16
`define FCL_PARAM_AW       4

// ==========================================================================
// Timing
`define FCL_CLK_HZ         20000000
`define FCL_LED_DELAY_S    5
`define FCL_PREOP_DELAY_S  5
`define FCL_SETTLE_CYC     8'h08

`endif

// ===== logic/fcl_param_mem.v
// Small parameter store with a registered read port.
`default_nettype none

module fcl_param_mem (
  input  wire        clk_i,
  input  wire        we_i,
  input  wire [3:0]  addr_i,
  input  wire [15:0] wdata_i,
  output reg  [15:0] rdata_o
);

  reg [15:0] mem [0:15];

  // ==========================================================================
  // Storage
  // Read first, then write; a same-cycle read returns the old word.
  always @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
    rdata_o <= mem[addr_i];
  end

endmodule

`default_nettype wire

// ===== bench/fcl_ee_model.sv
// Behavioural parameter store answering the loader's access port.
`default_nettype none
module fcl_ee_model (
  input  wire logic        clk_i,
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  output logic      [15:0] rdata_o = 16'h0000,
  output logic             done_o = 1'b0,
  output logic             err_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [16];
  int          fail_at = -1;
  int          wr_q [$];
  int          stall = 0;
  // ==========
  // Store access
  // Answers after a random stall. Idle data lines carry noise, because the
  // loader may only look at them together with done.
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    err_o <= 1'($urandom);
    rdata_o <= 16'($urandom);
    if (req_i === 1'b1 && !done_o) begin
      if (stall > 0) begin
        stall <= stall - 1;
      end else begin
        done_o <= 1'b1;
        err_o <= we_i && fail_at == int'(addr_i);
        stall <= $urandom_range(3);
        if (we_i) begin
          mem[addr_i] <= wdata_i;
          wr_q.push_back({addr_i, wdata_i});
        end else begin
          rdata_o <= mem[addr_i];
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== bench/fcl_loader_asserts.sv
// Concurrent checks on the ports of the switch configuration loader.
`default_nettype none
module fcl_loader_chk #(
  parameter [31:0] LED_CYC   = 32'h0000_00c8,
  parameter [31:0] PREOP_CYC = 32'h0000_012c
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ee_req_o,
  input wire logic        ee_we_o,
  input wire logic [3:0]  ee_addr_o,
  input wire logic [15:0] ee_wdata_o,
  input wire logic        ee_done_i,
  input wire logic        bus_en_o,
  input wire logic [3:0]  baud_code_o,
  input wire logic [9:0]  baud_kbps_o,
  input wire logic [6:0]  node_id_o,
  input wire logic        preop_o,
  input wire logic        emcy_o,
  input wire logic        rx_led_o,
  input wire logic        alarm_led_o,
  input wire logic        alarm_relay_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] up;
  logic [9:0]  kt [16] = '{0: 10'h00a, 1: 10'h014, 2: 10'h032, 3: 10'h064, 4: 10'h07d,
                           5: 10'h0fa, 6: 10'h1f4, 7: 10'h320, 8: 10'h3e8, default: 10'h000};
  // ==========
  // Helpers
  // Cycles since reset release; it saturates so a long run never wraps.
  always @(posedge clk_i) begin
    if (rst_i)
      up <= 32'h0;
    else if (up != 32'hffff_ffff)
      up <= up + 32'h1;
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence ee_wait;
    ee_req_o && !ee_done_i;
  endsequence
  sequence ee_held;
    ee_req_o && $stable(ee_addr_o) && $stable(ee_we_o) && $stable(ee_wdata_o);
  endsequence
  sequence ee_end;
    ee_req_o && ee_done_i;
  endsequence
  // ==========
  // Properties
  baud_map_a: assert property (
    bus_en_o |-> baud_code_o <= 4'h8 && baud_kbps_o == kt[baud_code_o])
    else $error("rate does not match the baud code");
  node_ok_a: assert property (bus_en_o |-> node_id_o != 7'h00)
    else $error("node on bus with number zero");
  sample_once_a: assert property (
    bus_en_o |=> $stable(baud_code_o) && $stable(node_id_o))
    else $error("sampled switch value changed");
  ee_hold_a: assert property (ee_wait |=> ee_held)
    else $error("store request changed before done");
  ee_drop_a: assert property (ee_end |=> !ee_req_o)
    else $error("store request not released after done");
  preop_late_a: assert property ($rose(preop_o) |-> bus_en_o && up >= PREOP_CYC)
    else $error("pre-operational too early or off bus");
  emcy_once_a: assert property (emcy_o |-> preop_o ##1 !emcy_o)
    else $error("emergency pulse malformed");
  led_late_a: assert property ($rose(rx_led_o) |-> up >= LED_CYC)
    else $error("receive lamp lit too early");
  alarm_pair_a: assert property (alarm_led_o |-> alarm_relay_o ##1 alarm_led_o)
    else $error("alarm lamp and relay disagree or alarm dropped");
  rx_svc_a: assert property (rx_led_o |-> !bus_en_o && !alarm_led_o)
    else $error("receive lamp lit outside a good service run");
endmodule
bind fcl_loader fcl_loader_chk #(.LED_CYC(LED_CYC), .PREOP_CYC(PREOP_CYC)) fcl_chk_inst (
  .clk_i, .rst_i, .ee_req_o, .ee_we_o, .ee_addr_o, .ee_wdata_o, .ee_done_i, .bus_en_o,
  .baud_code_o, .baud_kbps_o, .node_id_o, .preop_o, .emcy_o, .rx_led_o, .alarm_led_o,
  .alarm_relay_o);
`default_nettype wire

// ===== bench/tb.sv
// Self-checking bench for the switch configuration loader.
`default_nettype none
`include "fcl_map.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00, node_sw_i = 8'h20;
  logic [3:0]  wb_sel_i = 4'hf, baud_sw_i = 4'h1;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic        cfg_change_i = 1'b0, reset_node_i = 1'b0, wb_ack_o, ee_req_o, ee_we_o;
  logic        ee_done_i, ee_err_i, bus_en_o, preop_o, emcy_o, rx_led_o, alarm_led_o;
  logic        alarm_relay_o, irq_o;
  logic [3:0]  ee_addr_o, baud_code_o;
  logic [15:0] ee_wdata_o, ee_rdata_i, em [16];
  logic [9:0]  baud_kbps_o;
  logic [6:0]  node_id_o;
  int          n_errors = 0, compares = 0;
  int          n_emcy = 0;
  logic [9:0]  kt [16] = '{0: 10'h00a, 1: 10'h014, 2: 10'h032, 3: 10'h064, 4: 10'h07d,
                           5: 10'h0fa, 6: 10'h1f4, 7: 10'h320, 8: 10'h3e8, default: 10'h000};
  logic [7:0]  nd [9] = '{8'h00, 8'h01, 8'h20, 8'h29, 8'h7e, 8'h7f, 8'h80, 8'h82, 8'h8f};
  wire  [3:0]  st = {alarm_led_o, preop_o, rx_led_o, bus_en_o};

  fcl_loader #(.LED_CYC(32'h0000_00c8), .PREOP_CYC(32'h0000_012c)) fcl_loader_inst (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .baud_sw_i, .node_sw_i, .cfg_change_i, .reset_node_i, .ee_req_o,
    .ee_we_o, .ee_addr_o, .ee_wdata_o, .ee_rdata_i, .ee_done_i, .ee_err_i, .bus_en_o,
    .baud_code_o, .baud_kbps_o, .node_id_o, .preop_o, .emcy_o, .rx_led_o, .alarm_led_o,
    .alarm_relay_o, .irq_o);
  fcl_ee_model ee_inst (.clk_i, .req_i(ee_req_o), .we_i(ee_we_o), .addr_i(ee_addr_o),
    .wdata_i(ee_wdata_o), .rdata_o(ee_rdata_i), .done_o(ee_done_i), .err_o(ee_err_i));

  // ==========
  // Clock of 50 ns period.
  always #25 clk_i = ~clk_i;

  // Emergency pulses over the whole run; each one lasts a single cycle.
  always @(posedge clk_i) begin
    if (emcy_o === 1'b1)
      n_emcy++;
  end

  task automatic summarize();
    $display("errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic hang();
    n_errors++;
    summarize();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One classic cycle; held until ack is sampled, then one idle cycle.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_sel_i <= 4'hf;
    wb_adr_i <= a;
    wb_dat_i <= d;
    for (i = 0; i < 99; i++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1)
        break;
    end
    if (i == 99)
      hang();
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // Waits for a status line; a time-out is an error only when the rise is expected.
  task automatic wt(input int k, input int n, input logic e);
    int i;
    for (i = 0; i < n && st[k] !== 1'b1; i++)
      @(posedge clk_i);
    if (e && i == n)
      hang();
  endtask
  task automatic cmp_def();
    int i;
    for (i = 0; i < 3000 && ee_inst.wr_q.size() < 16; i++)
      @(posedge clk_i);
    if (i == 3000)
      hang();
    // Let the engine take the last answer and return to its resting state.
    repeat (4) @(posedge clk_i);
    for (i = 0; i < 16; i++)
      chk(ee_inst.wr_q[i], {i[3:0], `FCL_PARAM_DEFAULT});
    ee_inst.wr_q.delete();
  endtask
  // Switches are set during reset and held, as a power-up would see them.
  task automatic boot(input logic [3:0] b, input logic [7:0] n);
    rst_i <= 1'b1;
    baud_sw_i <= b;
    node_sw_i <= n;
    repeat (10) @(posedge clk_i);
    chk(baud_code_o, `FCL_BAUD_DEFAULT);
    ee_inst.wr_q.delete();
    rst_i <= 1'b0;
  endtask

  // ==========
  // Main sequence
  initial begin
    int c, k;
    logic v;
    logic [15:0] d;
    void'($urandom(44611));
    for (c = 0; c < 16; c++) begin
      boot(c[3:0], `FCL_NODE_DEFAULT);
      wt(0, 300, c < 9);
      chk(bus_en_o, c < 9);
      chk(baud_kbps_o, kt[c]);
      wb(1'b0, `FCL_OFS_STATUS, 32'h0);
      chk(q[13:0], {1'b1, c < 9, 8'h20, c[3:0]});
    end
    for (c = 0; c < 9; c++) begin
      v = nd[c] != 8'h00 && !nd[c][7];
      boot(`FCL_BAUD_DEFAULT, nd[c]);
      wt(0, 300, v);
      chk(node_id_o, nd[c][6:0]);
      wb(1'b0, `FCL_OFS_STATUS, 32'h0);
      chk({q[15:14], q[11:4]}, {v, nd[c][7], nd[c]});
      chk(ee_inst.wr_q.size(), 0);
    end
    boot(`FCL_BAUD_DEFAULT, `FCL_SVC_RESTORE);
    cmp_def();
    wt(1, 400, 1'b1);
    chk({rx_led_o, bus_en_o, alarm_led_o}, 3'b100);
    ee_inst.fail_at = 5;
    boot(`FCL_BAUD_DEFAULT, `FCL_SVC_RESTORE);
    wt(3, 300, 1'b1);
    chk(alarm_relay_o, 1'b1);
    repeat (250) @(posedge clk_i);
    chk(rx_led_o, 1'b0);
    ee_inst.fail_at = -1;
    for (k = 0; k < 16; k++) begin
      em[k] = 16'($urandom);
      ee_inst.mem[k] = em[k];
    end
    boot(`FCL_BAUD_MAX, `FCL_NODE_MAX);
    wt(0, 300, 1'b1);
    node_sw_i <= 8'h05;
    baud_sw_i <= 4'h3;
    for (k = 0; k < 16; k++) begin
      wb(1'b0, 8'(`FCL_OFS_PARAM + 4 * k), 32'h0);
      chk(q[15:0], em[k]);
    end
    chk({baud_code_o, node_id_o}, {4'h8, 7'h7f});
    d = 16'($urandom);
    wb(1'b1, 8'h4c, {16'h0, d});
    for (k = 0; k < 300 && ee_inst.wr_q.size() < 1; k++)
      @(posedge clk_i);
    if (k == 300)
      hang();
    chk(ee_inst.wr_q.size() > 0 ? ee_inst.wr_q[0] : -1, {4'h3, d});
    ee_inst.wr_q.delete();
    wb(1'b0, 8'h30, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, `FCL_OFS_IRQ_MASK, 32'h0);
    chk(q[4:0], `FCL_MASK_RESET);
    cfg_change_i <= 1'b1;
    @(posedge clk_i);
    cfg_change_i <= 1'b0;
    cmp_def();
    wb(1'b0, `FCL_OFS_IRQ_STAT, 32'h0);
    chk({q[4:3], q[1:0], irq_o}, 5'b01010);
    wb(1'b1, `FCL_OFS_IRQ_MASK, 32'h08);
    @(posedge clk_i);
    chk(irq_o, 1'b1);
    wb(1'b1, `FCL_OFS_IRQ_STAT, 32'h08);
    @(posedge clk_i);
    chk(irq_o, 1'b0);
    wt(2, 400, 1'b1);
    reset_node_i <= 1'b1;
    @(posedge clk_i);
    reset_node_i <= 1'b0;
    cmp_def();
    wb(1'b0, 8'h4c, 32'h0);
    chk(q[15:0], `FCL_PARAM_DEFAULT);
    wb(1'b1, `FCL_OFS_CTRL, 32'h1);
    cmp_def();
    wb(1'b0, `FCL_OFS_IRQ_STAT, 32'h0);
    chk({q[4], q[2]}, 2'b11);
    chk(n_emcy, 1);
    summarize();
  end
endmodule
`default_nettype wire
